// *** pkg/phcr_pkg.sv ***
// constants and carrier types for the configuration header register bank
package phcr_pkg;

  // ==========================================================================
  // register offsets (byte addresses, same in both views)
  localparam logic [7:0] HDR_WORD_OFS = 8'h0C;
  localparam logic [7:0] BASE_LO_OFS = 8'h10;
  localparam logic [7:0] BASE_HI_OFS = 8'h14;
  localparam logic [7:0] SUBSYS_OFS = 8'h2C;

  // ==========================================================================
  // line size / tenure timer / header type word
  localparam logic [7:0] LINE_SIZE_OK = 8'h08;
  localparam logic [7:0] LINE_SIZE_RST = 8'h00;
  localparam logic [7:0] TENURE_RST_PCI = 8'h00;
  localparam logic [7:0] TENURE_RST_PCIX = 8'h40;
  localparam int TENURE_STEP_BITS = 3;
  localparam logic [7:0] HEADER_TYPE = 8'h00;
  localparam logic [7:0] HDR_TOP_BYTE = 8'h00;

  // ==========================================================================
  // window base pair
  localparam int BASE_LO_LSB = 12;
  localparam logic [19:0] BASE_LO_RST = 20'h00000;
  localparam logic [7:0] BASE_LO_RSVD = 8'h00;
  localparam logic PREFETCH_IND = 1'b0;
  localparam logic [1:0] MEM_TYPE = 2'h2;
  localparam logic MEM_SPACE_IND = 1'b0;
  localparam logic [31:0] BASE_HI_RST = 32'h00000000;

  // ==========================================================================
  // subsystem identity
  localparam logic [15:0] SUBSYS_ID_RST = 16'h0000;

  // ==========================================================================
  // strap settle count and master commands
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  localparam logic [3:0] CMD_MEM_WR_INV = 4'hF;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;

  // one register access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } phcr_req_t;

  // one register access answer
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } phcr_rsp_t;

endpackage : phcr_pkg

// *** rtl/phcr_regs.sv ***
// configuration header register bank with bus tenure timer
`timescale 1ns/100ps

// Operation
// - line size keeps a written 0x08; any other written value leaves 0x00
// - tenure timer resets to 0x00 in conventional mode, 0x40 in extended mode
// - timer limits burst clocks from burst start, then bus is released once grant is withdrawn
// - tenure timer is writable only in steps of eight clocks
// - header type reads 0x00, bits 31:24 read zero, both read-only
// - memory write and invalidate is never issued by this device
// - lower base bits 31:12 writable, reset zero; bits 11:4 read zero
// - prefetch indicator bit 3 reads zero, read-only
// - memory type bits fixed at 10b for 64-bit placement
// - bit 0 reads zero: window is memory space only
// - upper base is fully writable 32 bits, reset zero
// - subsystem fields read-only from config view, writable from window view
// - subsystem id returns to 0x0000 at reset release
// - subsystem vendor loads the maker vendor code at reset release
module phcr_regs
  import phcr_pkg::*;
#(
  parameter logic [15:0] VENDOR_CODE = 16'h5A5A  // arbitrary value
) (
  input wire logic ref_clk,          // bus clock, 10 MHz
  input wire logic nrst,             // bus reset, active low, async
  input wire logic clk_en,           // freezes all state but the reset synchroniser while low
  input wire phcr_req_t cfg_req,     // configuration space view access
  output phcr_rsp_t cfg_rsp,         // configuration view answer
  input wire phcr_req_t win_req,     // combined register window access
  output phcr_rsp_t win_rsp,         // window view answer
  input wire logic pcix_mode_pin,    // high when bus runs in extended mode
  input wire logic gnt_n_pin,        // bus grant pin, active low
  input wire logic burst_start,      // master burst begins, one cycle
  input wire logic burst_active,     // master burst in progress
  input wire logic [3:0] cmd_in,     // command from master engine
  output logic [3:0] cmd_out,        // command driven onto the bus
  output logic release_bus,          // tenure expired, give up bus
  output logic [63:0] window_base,   // register window base address
  output logic [7:0] line_size       // advertised line size
);

  // ==========================================================================
  // reset and pin synchronisers
  logic rst_meta;
  logic rst_n;
  logic pcix_meta;
  logic pcix_sync;
  logic gnt_meta;
  logic gnt_n_sync;

  // reset release through two flops, assert at once
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // mode strap and grant pin pass two flops before use
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pcix_meta <= 1'b0;
      pcix_sync <= 1'b0;
      gnt_meta <= 1'b1;
      gnt_n_sync <= 1'b1;
    end else if (clk_en) begin
      pcix_meta <= pcix_mode_pin;
      pcix_sync <= pcix_meta;
      gnt_meta <= gnt_n_pin;
      gnt_n_sync <= gnt_meta;
    end
  end

  // ==========================================================================
  // byte lane merge and address decode
  function automatic logic [31:0] merge_be(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0] be
  );
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_be

  function automatic logic hit(input phcr_req_t req, input logic [7:0] ofs);
    return req.wr && (req.addr[7:2] == ofs[7:2]);
  endfunction : hit

  // writes from either view, subsystem from the window view only; window view wins on a same-cycle clash
  logic hdr_wr;
  logic base_lo_wr;
  logic base_hi_wr;
  logic sub_wr;

  always_comb begin
    hdr_wr = hit(cfg_req, HDR_WORD_OFS) || hit(win_req, HDR_WORD_OFS);
    base_lo_wr = hit(cfg_req, BASE_LO_OFS) || hit(win_req, BASE_LO_OFS);
    base_hi_wr = hit(cfg_req, BASE_HI_OFS) || hit(win_req, BASE_HI_OFS);
    sub_wr = hit(win_req, SUBSYS_OFS);
  end

  // request selected for shared registers; window request whenever the window view hits, config request otherwise
  phcr_req_t hdr_req;
  phcr_req_t lo_req;
  phcr_req_t hi_req;

  always_comb begin
    hdr_req = hit(win_req, HDR_WORD_OFS) ? win_req : cfg_req;
    lo_req = hit(win_req, BASE_LO_OFS) ? win_req : cfg_req;
    hi_req = hit(win_req, BASE_HI_OFS) ? win_req : cfg_req;
  end

  // ==========================================================================
  // line size field
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_size <= LINE_SIZE_RST;
    end else if (clk_en && hdr_wr && hdr_req.be[0]) begin
      if (hdr_req.wdata[7:0] == LINE_SIZE_OK) begin
        line_size <= LINE_SIZE_OK;
      end else begin
        line_size <= LINE_SIZE_RST;
      end
    end
  end

  // ==========================================================================
  // tenure timer, coarse bits only; strap applied once synchroniser settles
  logic [7-TENURE_STEP_BITS:0] tenure_hi;
  logic [1:0] settle_cnt;
  logic strap_done;
  logic [7:0] tenure_val;
  logic tenure_sw_wr;

  assign tenure_sw_wr = hdr_wr && hdr_req.be[1];
  assign tenure_val = {tenure_hi, {TENURE_STEP_BITS{1'b0}}};

  // settle counter for the mode strap after reset release
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_cnt <= 2'h0;
      strap_done <= 1'b0;
    end else if (clk_en && !strap_done) begin
      settle_cnt <= settle_cnt + 2'h1;
      if (settle_cnt == STRAP_SETTLE || tenure_sw_wr) begin
        strap_done <= 1'b1;
      end
    end
  end

  // timer field: strap picks the reset value, software steps of eight
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tenure_hi <= TENURE_RST_PCI[7:TENURE_STEP_BITS];
    end else if (clk_en) begin
      if (tenure_sw_wr) begin
        tenure_hi <= hdr_req.wdata[15:8+TENURE_STEP_BITS];
      end else if (!strap_done && settle_cnt == STRAP_SETTLE) begin
        if (pcix_sync) begin
          tenure_hi <= TENURE_RST_PCIX[7:TENURE_STEP_BITS];
        end else begin
          tenure_hi <= TENURE_RST_PCI[7:TENURE_STEP_BITS];
        end
      end
    end
  end

  // ==========================================================================
  // window base pair
  logic [19:0] base_lo_bits;
  logic [31:0] base_hi_bits;
  logic [31:0] base_lo_merged;

  assign base_lo_merged = merge_be({base_lo_bits, 12'h000}, lo_req.wdata, lo_req.be);

  // lower base: only the address bits take writes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      base_lo_bits <= BASE_LO_RST;
    end else if (clk_en && base_lo_wr) begin
      base_lo_bits <= base_lo_merged[31:BASE_LO_LSB];
    end
  end

  // upper base: all 32 bits writable
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      base_hi_bits <= BASE_HI_RST;
    end else if (clk_en && base_hi_wr) begin
      base_hi_bits <= merge_be(base_hi_bits, hi_req.wdata, hi_req.be);
    end
  end

  assign window_base = {base_hi_bits, base_lo_bits, 12'h000};

  // ==========================================================================
  // subsystem identity, writable through the window view only
  logic [15:0] subsys_id;
  logic [15:0] subsys_vendor;
  logic [31:0] sub_merged;

  assign sub_merged = merge_be({subsys_id, subsys_vendor}, win_req.wdata, win_req.be);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      subsys_id <= SUBSYS_ID_RST;
      subsys_vendor <= VENDOR_CODE;
    end else if (clk_en && sub_wr) begin
      subsys_id <= sub_merged[31:16];
      subsys_vendor <= sub_merged[15:0];
    end
  end

  // ==========================================================================
  // read image, identical for both views
  function automatic logic [31:0] read_word(input logic [7:0] addr);
    logic [31:0] res;
    res = 32'h00000000;
    unique case (addr[7:2])
      HDR_WORD_OFS[7:2]: begin
        res = {HDR_TOP_BYTE, HEADER_TYPE, tenure_val, line_size};
      end
      BASE_LO_OFS[7:2]: begin
        res = {base_lo_bits, BASE_LO_RSVD, PREFETCH_IND,
               MEM_TYPE, MEM_SPACE_IND};
      end
      BASE_HI_OFS[7:2]: begin
        res = base_hi_bits;
      end
      SUBSYS_OFS[7:2]: begin
        res = {subsys_id, subsys_vendor};
      end
      default: begin
        res = 32'h00000000;  // unmapped reads zero
      end
    endcase
    return res;
  endfunction : read_word

  // answers registered one cycle after each access
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rsp <= '0;
      win_rsp <= '0;
    end else if (clk_en) begin
      cfg_rsp.ack <= cfg_req.wr || cfg_req.rd;
      cfg_rsp.rdata <= cfg_req.rd ? read_word(cfg_req.addr) : 32'h00000000;
      win_rsp.ack <= win_req.wr || win_req.rd;
      win_rsp.rdata <= win_req.rd ? read_word(win_req.addr) : 32'h00000000;
    end
  end

  // ==========================================================================
  // bus tenure counter
  logic [7:0] tenure_cnt;

  // load at burst start, count down every clock of the burst until zero, then hold
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tenure_cnt <= 8'h00;
    end else if (clk_en) begin
      if (burst_start) begin
        tenure_cnt <= tenure_val;
      end else if (burst_active && tenure_cnt != 8'h00) begin
        tenure_cnt <= tenure_cnt - 8'h01;
      end
    end
  end

  // release once count is spent and grant has been withdrawn
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      release_bus <= 1'b0;
    end else if (clk_en) begin
      release_bus <= burst_active && !burst_start &&
                     (tenure_cnt == 8'h00) && gnt_n_sync;
    end
  end

  // ==========================================================================
  // command filter: invalidating writes become plain memory writes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_out <= CMD_MEM_WR;
    end else if (clk_en) begin
      if (cmd_in == CMD_MEM_WR_INV) begin
        cmd_out <= CMD_MEM_WR;
      end else begin
        cmd_out <= cmd_in;
      end
    end
  end

endmodule : phcr_regs

// *** sim/phcr_host_model.sv ***
// host side model: bus grant and bus mode straps
`timescale 1ns/100ps
module phcr_host_model (
  input wire logic ref_clk,     // bus clock
  input wire logic mode_x,      // extended mode request
  input wire logic take_gnt,    // withdraw the grant
  output logic gnt_n_pin,       // grant, active low
  output logic pcix_mode_pin    // mode strap
);
  // =====================================================
  // grant is registered, as an arbiter would drive it
  initial gnt_n_pin = 1'b0;
  always @(posedge ref_clk) begin
    gnt_n_pin <= take_gnt;
  end
  assign pcix_mode_pin = mode_x;
endmodule : phcr_host_model

// *** sim/phcr_regs_asserts.sv ***
// assertion checker for the configuration header register bank
`timescale 1ns/100ps
module phcr_regs_asserts
  import phcr_pkg::*;
(
  input wire logic ref_clk,             // bus clock
  input wire logic nrst,                // reset, active low
  input wire logic clk_en,              // clock enable
  input wire phcr_req_t cfg_req,        // config view request
  input wire phcr_rsp_t cfg_rsp,        // config view answer
  input wire phcr_req_t win_req,        // window view request
  input wire logic burst_start,         // burst begins
  input wire logic burst_active,        // burst in progress
  input wire logic [3:0] cmd_in,        // master command
  input wire logic [3:0] cmd_out,       // bus command
  input wire logic release_bus,         // tenure spent
  input wire logic [63:0] window_base,  // window base
  input wire logic [7:0] line_size      // line size
);
  // =====================================================
  // checks
  // design runs from a delayed reset copy; keep checks off until it is out
  logic [2:0] rst_pipe;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_pipe <= 3'h0;
    end else begin
      rst_pipe <= {rst_pipe[1:0], 1'b1};
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_pipe[2]);
  a_cfg_ack_next: assert property ((cfg_req.wr || cfg_req.rd) && clk_en |=> cfg_rsp.ack)
    else $error("config access not answered");
  a_line_size_legal: assert property (line_size == 8'h08 || line_size == 8'h00)
    else $error("line size holds an illegal value");
  a_line_keep_08: assert property (win_req.wr && clk_en && win_req.addr[7:2] == 6'h03 &&
    win_req.be[0] && win_req.wdata[7:0] == 8'h08 |=> line_size == 8'h08)
    else $error("line size not kept");
  a_line_drop_other: assert property (win_req.wr && clk_en && win_req.addr[7:2] == 6'h03 &&
    win_req.be[0] && win_req.wdata[7:0] != 8'h08 |=> line_size == 8'h00)
    else $error("line size not cleared");
  a_no_invalidate: assert property (cmd_out != 4'hF)
    else $error("invalidate command issued");
  a_cmd_passes: assert property (clk_en && cmd_in != 4'hF |=> cmd_out == $past(cmd_in))
    else $error("command not passed on");
  a_base_low_clear: assert property (window_base[11:0] == 12'h000)
    else $error("window base low bits set");
  a_base_fixed_bits: assert property (cfg_req.rd && clk_en && cfg_req.addr[7:2] == 6'h04
    |=> cfg_rsp.rdata[11:0] == 12'h004)
    else $error("base fixed bits wrong");
  a_hdr_top_zero: assert property (cfg_req.rd && clk_en && cfg_req.addr[7:2] == 6'h03
    |=> cfg_rsp.rdata[31:16] == 16'h0000)
    else $error("header type bits not zero");
  a_release_cause: assert property ($rose(release_bus)
    |-> $past(burst_active) && !$past(burst_start))
    else $error("bus released outside a burst");
  c_line_write: cover property (line_size == 8'h08);
  c_release: cover property ($rose(release_bus));
  c_invalidate_in: cover property (cmd_in == 4'hF);
endmodule : phcr_regs_asserts

bind phcr_regs phcr_regs_asserts i_chk (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en),
  .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .win_req(win_req), .burst_start(burst_start),
  .burst_active(burst_active), .cmd_in(cmd_in), .cmd_out(cmd_out),
  .release_bus(release_bus), .window_base(window_base), .line_size(line_size));

// *** sim/pci_header_cfg_regs_test.sv ***
// self-checking testbench for the configuration header register bank
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module pci_header_cfg_regs_test
  import phcr_pkg::*;
;
  localparam logic [15:0] VC = 16'hC3A5;  // arbitrary value
  logic ref_clk, nrst, clk_en, mode_x, take_gnt, gnt_n_pin, pcix_mode_pin;
  logic burst_start, burst_active, release_bus;
  logic [3:0] cmd_in, cmd_out;
  logic [63:0] window_base;
  logic [7:0] line_size;
  phcr_req_t cfg_req, win_req;
  phcr_rsp_t cfg_rsp, win_rsp;
  int errors = 0;
  int checks_done = 0;

  // =====================================================
  // instances and clock
  phcr_regs #(.VENDOR_CODE(VC)) i_dut (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en),
    .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .win_req(win_req), .win_rsp(win_rsp),
    .pcix_mode_pin(pcix_mode_pin), .gnt_n_pin(gnt_n_pin), .burst_start(burst_start),
    .burst_active(burst_active), .cmd_in(cmd_in), .cmd_out(cmd_out),
    .release_bus(release_bus), .window_base(window_base), .line_size(line_size));
  phcr_host_model i_host (.ref_clk(ref_clk), .mode_x(mode_x), .take_gnt(take_gnt),
    .gnt_n_pin(gnt_n_pin), .pcix_mode_pin(pcix_mode_pin));
  always #50 ref_clk = ~ref_clk;

  // =====================================================
  // bus tasks
  task automatic acc(input logic v, input logic w, input logic [7:0] a, input logic [3:0] b,
                     input logic [31:0] d, output logic [31:0] q);
    phcr_req_t r;
    r = '{wr: w, rd: !w, addr: a, be: b, wdata: d};
    @(posedge ref_clk);
    if (v) win_req <= r;
    else cfg_req <= r;
    @(posedge ref_clk);
    cfg_req <= '0;
    win_req <= '0;
    #1;
    q = v ? win_rsp.rdata : cfg_rsp.rdata;
    `CHK("ack", 1'b1, (v ? win_rsp.ack : cfg_rsp.ack))
  endtask : acc
  task automatic wr(input logic v, input logic [7:0] a, input logic [3:0] b,
                    input logic [31:0] d);
    logic [31:0] q;
    acc(v, 1'b1, a, b, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ex);
    logic [31:0] q;
    acc(1'b0, 1'b0, a, 4'hF, 32'h0, q);
    `CHK($sformatf("reg %h", a), ex, q)
  endtask : rd
  task automatic rdw(input logic [7:0] a, input logic [31:0] ex);
    logic [31:0] q;
    acc(1'b1, 1'b0, a, 4'hF, 32'h0, q);
    `CHK($sformatf("win reg %h", a), ex, q)
  endtask : rdw
  task automatic do_reset(input logic m);
    @(posedge ref_clk);
    nrst <= 1'b0;
    mode_x <= m;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (10) @(posedge ref_clk);
  endtask : do_reset

  // =====================================================
  // scenarios
  task automatic t_regs;
    logic [7:0] vals [5] = '{8'h08, 8'h10, 8'h09, 8'h08, 8'hFF};
    rd(8'h0C, 32'h0000_0000);
    rd(8'h10, 32'h0000_0004);
    rd(8'h14, 32'h0000_0000);
    rd(8'h2C, {16'h0000, VC});
    rd(8'h30, 32'h0000_0000);
    for (int i = 0; i < 5; i++) begin
      wr(1'b1, 8'h0C, 4'h1, {24'h0, vals[i]});
      `CHK("line_size", ((vals[i] == 8'h08) ? 8'h08 : 8'h00), line_size)
    end
    wr(1'b0, 8'h0C, 4'hF, 32'hFFFF_FF08);
    rd(8'h0C, 32'h0000_F808);
    wr(1'b0, 8'h10, 4'hF, 32'hFFFF_FFFF);
    rd(8'h10, 32'hFFFF_F004);
    wr(1'b1, 8'h14, 4'hF, 32'h89AB_CDEF);
    rd(8'h14, 32'h89AB_CDEF);
    `CHK("window_base", 64'h89AB_CDEF_FFFF_F000, window_base)
    wr(1'b0, 8'h2C, 4'hF, 32'h1234_5678);
    rd(8'h2C, {16'h0000, VC});
    wr(1'b1, 8'h2C, 4'hF, 32'h1234_5678);
    rd(8'h2C, 32'h1234_5678);
    rdw(8'h0C, 32'h0000_F808);
    rdw(8'h10, 32'hFFFF_F004);
    rdw(8'h2C, 32'h1234_5678);
    $display("test registers done");
  endtask : t_regs
  task automatic t_burst(input logic wd);
    take_gnt <= wd;
    repeat (5) @(posedge ref_clk);
    burst_start <= 1'b1;
    burst_active <= 1'b1;
    @(posedge ref_clk);
    burst_start <= 1'b0;
    for (int n = 1; n <= 9; n++) begin
      @(posedge ref_clk);
      #1;
      `CHK("release_bus", (wd && n == 9), release_bus)
    end
    @(posedge ref_clk);
    burst_active <= 1'b0;
    take_gnt <= 1'b0;
    repeat (3) @(posedge ref_clk);
    $display("test burst done");
  endtask : t_burst
  task automatic t_cmd;
    @(posedge ref_clk);
    cmd_in <= 4'hF;
    @(posedge ref_clk);
    cmd_in <= 4'h6;
    #1;
    `CHK("cmd_out", 4'h7, cmd_out)
    @(posedge ref_clk);
    #1;
    `CHK("cmd_out", 4'h6, cmd_out)
    $display("test command done");
  endtask : t_cmd
  // a window write while the clock enable is low must leave no trace
  task automatic t_freeze;
    @(posedge ref_clk);
    clk_en <= 1'b0;
    win_req <= '{wr: 1'b1, rd: 1'b0, addr: BASE_HI_OFS, be: 4'hF, wdata: 32'h0};
    @(posedge ref_clk);
    clk_en <= 1'b1;
    win_req <= '0;
    #1;
    `CHK("frozen ack", 1'b0, win_rsp.ack)
    `CHK("frozen base", 64'h89AB_CDEF_FFFF_F000, window_base)
    rd(8'h14, 32'h89AB_CDEF);
    $display("test clock enable done");
  endtask : t_freeze

  // =====================================================
  // end of run
  task stop_test;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  // =====================================================
  // main sequence and watchdog
  initial begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    cfg_req = '0;
    win_req = '0;
    clk_en = 1'b1;
    mode_x = 1'b0;
    take_gnt = 1'b0;
    burst_start = 1'b0;
    burst_active = 1'b0;
    cmd_in = 4'h0;
    do_reset(1'b0);
    t_regs();
    t_freeze();
    wr(1'b0, 8'h0C, 4'h3, 32'h0000_0808);
    t_burst(1'b1);
    t_burst(1'b0);
    t_cmd();
    do_reset(1'b1);
    rd(8'h0C, 32'h0000_4000);
    stop_test();
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    errors++;
    stop_test();
  end
endmodule : pci_header_cfg_regs_test
